// [rtl/jmss_consts.svh]
`ifndef JMSS_CONSTS_SVH
`define JMSS_CONSTS_SVH
// Command codes issued on the command strobe
`define JMSS_CMD_CLEAR_X        6'h00
`define JMSS_CMD_CLEAR_PC       6'h01
`define JMSS_CMD_CLEAR_REP      6'h02
`define JMSS_CMD_ADDR_FIRST     6'h03
`define JMSS_CMD_ADDR_SECOND    6'h04
`define JMSS_CMD_READ           6'h05
`define JMSS_CMD_WRITE_FULL     6'h06
`define JMSS_CMD_SUB_X          6'h07
`define JMSS_CMD_CPL_X          6'h08
`define JMSS_CMD_SUB_ONE        6'h09
`define JMSS_CMD_CPL_PC         6'h0A
`define JMSS_CMD_ADD_X          6'h0B
`define JMSS_CMD_SET_X_ONE      6'h0C
`define JMSS_CMD_JUMP_TERM      6'h0D
`define JMSS_CMD_PC_TO_ADDR     6'h0E
`define JMSS_CMD_ADVANCE_PC     6'h0F
`define JMSS_CMD_CLEAR_CWR      6'h10
`define JMSS_CMD_END_TEST       6'h11
`define JMSS_CMD_ADDR_TO_PC     6'h12
`define JMSS_CMD_CLEAR_ADDR     6'h13
`define JMSS_CMD_SHIFT_Q_ONE    6'h14
`define JMSS_CMD_CLEAR_ACC      6'h15
`define JMSS_CMD_NOTQ_TO_X      6'h16
`define JMSS_CMD_SPLIT_ADD      6'h17
`define JMSS_CMD_ACCLO_TO_X     6'h18
`define JMSS_CMD_LOGICAL        6'h19
`define JMSS_CMD_EXTEND_ARITH   6'h1A
`define JMSS_CMD_CPL_Q          6'h1B
`define JMSS_CMD_SHIFT_ACC      6'h1C
`define JMSS_CMD_CLEAR_Q        6'h1D
`define JMSS_CMD_X_TO_Q         6'h1E
`define JMSS_CMD_SHIFT_Q        6'h1F
// Opcodes of the instructions served
`define JMSS_OP_EQ_REP          6'h00
`define JMSS_OP_MQ_SIGN         6'h01
`define JMSS_OP_SWITCH          6'h02
`define JMSS_OP_ACC_SIGN        6'h03
`define JMSS_OP_ACC_ZERO        6'h04
`define JMSS_OP_MASK_XFER       6'h05
`define JMSS_OP_MASK_ADD        6'h06
`define JMSS_OP_MASK_MERGE      6'h07
`define JMSS_OP_SHL_ACC         6'h08
`define JMSS_OP_SHL_MQ          6'h09
// Status bit positions
`define JMSS_MQ_SIGN_BIT        35
`define JMSS_ACC_SIGN_BIT       71
// Step list depth
`define JMSS_STEP_MAX           5'd24
`endif

// [rtl/jmss_pkg.sv]
package jmss_pkg;
    typedef enum logic [1:0] {
        JMSS_IDLE = 2'b00,
        JMSS_RUN  = 2'b01,
        JMSS_WAIT = 2'b10
    } jmss_state_t;

    // One issued command and the pulse it belongs to
    typedef struct packed {
        logic       valid;
        logic [5:0] code;
        logic [2:0] pulse;
        logic       waitDone;
    } jmss_cmd_t;

    // Machine flags sampled by the sequencer
    typedef struct packed {
        logic accSign;
        logic accZero;
        logic mqSign;
        logic [3:1] switchSel;
        logic firstIsAcc;
        logic countZero;
    } jmss_flags_t;
endpackage

// [rtl/jmss_sequencer.sv]
`timescale 1ns/1ns
`include "jmss_consts.svh"
module jmss_sequencer (
    input  wire logic              clk_sys,
    input  wire logic              nrst,
    input  wire logic              pulseEn,
    input  wire logic              start,
    input  wire logic [5:0]        opcode,
    input  wire jmss_pkg::jmss_flags_t flags,
    input  wire logic              unitDone,
    output jmss_pkg::jmss_cmd_t    cmd,
    output logic                   busy,
    output logic                   waiting
);
    jmss_pkg::jmss_state_t state_q, state_d;
    logic [4:0]  step_q, step_d;
    logic [5:0]  op_q, op_d;
    logic        took_q, took_d;
    jmss_pkg::jmss_cmd_t cmd_q, cmd_d;

    // Step table entry: code, pulse, wait-after, last
    logic [5:0] eCode;
    logic [2:0] ePulse;
    logic       eWait;
    logic       eLast;
    logic       eSkip;

    // Branch decision latched at step 0; the zero-test ops retake it after subtract-one
    logic takeNow;
    always_comb begin
        unique case (op_q)
            `JMSS_OP_MQ_SIGN:  takeNow = flags.mqSign;
            `JMSS_OP_ACC_SIGN: takeNow = flags.accSign;
            `JMSS_OP_SWITCH:   takeNow = ~|opcode[5:4] ? 1'b0 : 1'b0;
            default:           takeNow = flags.accZero;
        endcase
    end

    function automatic logic swTake(input logic [1:0] sel,
                                    input logic [3:1] sw);
        swTake = (sel == 2'd0) || sw[sel];
    endfunction

    always_comb begin
        eCode  = `JMSS_CMD_CLEAR_X;
        ePulse = 3'd0;
        eWait  = 1'b0;
        eLast  = 1'b0;
        eSkip  = 1'b0;
        unique case (op_q)
        `JMSS_OP_EQ_REP: begin
            unique case (step_q)
            5'd0: begin eCode = `JMSS_CMD_CLEAR_X; end
            5'd1: begin eCode = `JMSS_CMD_ADDR_FIRST; end
            5'd2: begin eCode = `JMSS_CMD_READ; eWait = 1'b1; end
            5'd3: begin eCode = `JMSS_CMD_SUB_X; ePulse = 3'd1;
                        eWait = 1'b1; end
            5'd4: begin eCode = `JMSS_CMD_CPL_X; ePulse = 3'd2; end
            5'd5: begin eCode = `JMSS_CMD_SUB_ONE; ePulse = 3'd2;
                        eWait = 1'b1; end
            5'd6: begin eCode = `JMSS_CMD_CPL_PC; ePulse = 3'd3;
                        eSkip = ~took_q; end
            5'd7: begin eCode = `JMSS_CMD_ADD_X; ePulse = 3'd3;
                        eWait = 1'b1; end
            5'd8: begin eCode = `JMSS_CMD_SET_X_ONE; ePulse = 3'd4; end
            5'd9: begin eCode = `JMSS_CMD_ADD_X; ePulse = 3'd5;
                        eWait = 1'b1; end
            5'd10: begin eCode = `JMSS_CMD_JUMP_TERM; ePulse = 3'd5;
                         eSkip = ~took_q; end
            5'd11: begin eCode = `JMSS_CMD_PC_TO_ADDR; ePulse = 3'd5;
                         eSkip = ~took_q; end
            5'd12: begin eCode = `JMSS_CMD_CLEAR_CWR; ePulse = 3'd5;
                         eSkip = ~took_q; end
            5'd13: begin eCode = `JMSS_CMD_END_TEST; ePulse = 3'd5;
                         eSkip = took_q; end
            5'd14: begin eCode = `JMSS_CMD_ADVANCE_PC; ePulse = 3'd5;
                         eSkip = took_q; end
            default: begin eCode = `JMSS_CMD_CLEAR_X; ePulse = 3'd5;
                           eSkip = 1'b1; eWait = 1'b1;
                           eLast = 1'b1; end
            endcase
        end
        `JMSS_OP_MQ_SIGN, `JMSS_OP_SWITCH, `JMSS_OP_ACC_SIGN: begin
            unique case (step_q)
            5'd0: begin eCode = `JMSS_CMD_CLEAR_X; end
            5'd1: begin eCode = `JMSS_CMD_CLEAR_PC;
                        eSkip = (op_q == `JMSS_OP_SWITCH) && ~took_q;
                  end
            5'd2: begin eCode = `JMSS_CMD_CLEAR_REP;
                        eSkip = (op_q == `JMSS_OP_SWITCH) && ~took_q;
                  end
            5'd3: begin
                eCode = (took_q && op_q != `JMSS_OP_SWITCH)
                      ? `JMSS_CMD_ADDR_FIRST
                      : `JMSS_CMD_ADDR_SECOND;
            end
            5'd4: begin eCode = `JMSS_CMD_ADDR_TO_PC; ePulse = 3'd5;
                        eSkip = (op_q == `JMSS_OP_SWITCH) && ~took_q;
                  end
            5'd5: begin eCode = `JMSS_CMD_CLEAR_ADDR; ePulse = 3'd5;
                        eLast = (op_q != `JMSS_OP_MQ_SIGN); end
            default: begin eCode = `JMSS_CMD_SHIFT_Q_ONE; ePulse = 3'd5;
                           eLast = 1'b1; end
            endcase
        end
        `JMSS_OP_ACC_ZERO: begin
            unique case (step_q)
            5'd0: begin eCode = `JMSS_CMD_CLEAR_X; end
            5'd1: begin eCode = `JMSS_CMD_CLEAR_PC; end
            5'd2: begin eCode = `JMSS_CMD_CLEAR_REP; end
            5'd3: begin eCode = `JMSS_CMD_SUB_ONE;
                        eWait = 1'b1; end
            5'd4: begin eCode = took_q ? `JMSS_CMD_ADDR_SECOND
                                       : `JMSS_CMD_ADDR_FIRST;
                        ePulse = 3'd1; end
            5'd5: begin eCode = `JMSS_CMD_SET_X_ONE; ePulse = 3'd1; end
            5'd6: begin eCode = `JMSS_CMD_ADDR_TO_PC; ePulse = 3'd5; end
            5'd7: begin eCode = `JMSS_CMD_CLEAR_ADDR; ePulse = 3'd5; end
            default: begin eCode = `JMSS_CMD_ADD_X; ePulse = 3'd5;
                           eWait = 1'b1; eLast = 1'b1; end
            endcase
        end
        `JMSS_OP_MASK_XFER, `JMSS_OP_MASK_ADD: begin
            unique case (step_q)
            5'd0: begin eCode = `JMSS_CMD_CLEAR_X; end
            5'd1: begin eCode = `JMSS_CMD_CLEAR_ACC;
                        eSkip = (op_q == `JMSS_OP_MASK_ADD); end
            5'd2: begin eCode = `JMSS_CMD_ADDR_FIRST; end
            5'd3: begin eCode = `JMSS_CMD_READ; eWait = 1'b1; end
            5'd4: begin eCode = `JMSS_CMD_NOTQ_TO_X; ePulse = 3'd1; end
            5'd5: begin eCode = `JMSS_CMD_SPLIT_ADD; ePulse = 3'd2;
                        eWait = 1'b1; end
            5'd6: begin eCode = `JMSS_CMD_CLEAR_X; ePulse = 3'd3;
                        eSkip = (op_q != `JMSS_OP_MASK_ADD); end
            5'd7: begin eCode = `JMSS_CMD_ACCLO_TO_X; ePulse = 3'd5;
                        eSkip = (op_q != `JMSS_OP_MASK_ADD); end
            5'd8: begin eCode = `JMSS_CMD_ADDR_SECOND; ePulse = 3'd5; end
            default: begin eCode = `JMSS_CMD_WRITE_FULL; ePulse = 3'd5;
                           eWait = 1'b1; eLast = 1'b1; end
            endcase
        end
        `JMSS_OP_MASK_MERGE: begin
            unique case (step_q)
            5'd0: begin eCode = `JMSS_CMD_CLEAR_X; end
            5'd1: begin eCode = `JMSS_CMD_CLEAR_ACC; end
            5'd2: begin eCode = `JMSS_CMD_ADDR_FIRST; end
            5'd3: begin eCode = `JMSS_CMD_READ; eWait = 1'b1; end
            5'd4: begin eCode = `JMSS_CMD_LOGICAL; ePulse = 3'd1; end
            5'd5: begin eCode = `JMSS_CMD_EXTEND_ARITH; ePulse = 3'd1;
                        eWait = 1'b1; end
            5'd6: begin eCode = `JMSS_CMD_CPL_Q; ePulse = 3'd1; end
            5'd7: begin eCode = `JMSS_CMD_ADDR_SECOND; ePulse = 3'd2; end
            5'd8: begin eCode = `JMSS_CMD_READ; ePulse = 3'd2;
                        eWait = 1'b1; end
            5'd9: begin eCode = `JMSS_CMD_LOGICAL; ePulse = 3'd3; end
            5'd10: begin eCode = `JMSS_CMD_EXTEND_ARITH; ePulse = 3'd3;
                         eWait = 1'b1; end
            5'd11: begin eCode = `JMSS_CMD_CPL_Q; ePulse = 3'd3; end
            5'd12: begin eCode = `JMSS_CMD_ACCLO_TO_X; ePulse = 3'd5; end
            5'd13: begin eCode = `JMSS_CMD_ADDR_SECOND; ePulse = 3'd5; end
            default: begin eCode = `JMSS_CMD_WRITE_FULL; ePulse = 3'd5;
                           eWait = 1'b1; eLast = 1'b1; end
            endcase
        end
        default: begin
            // Both left shifts; Acc and Q variants share the write tail
            unique case (step_q)
            5'd0: begin eCode = `JMSS_CMD_CLEAR_X; end
            5'd1: begin eCode = (op_q == `JMSS_OP_SHL_ACC)
                              ? `JMSS_CMD_CLEAR_ACC : `JMSS_CMD_CLEAR_X;
                        eSkip = (op_q == `JMSS_OP_SHL_ACC)
                              && flags.firstIsAcc; end
            5'd2: begin eCode = `JMSS_CMD_ADDR_FIRST; end
            5'd3: begin eCode = `JMSS_CMD_READ; eWait = 1'b1;
                        eSkip = (op_q == `JMSS_OP_SHL_ACC)
                              && flags.firstIsAcc; end
            5'd4: begin eCode = (op_q == `JMSS_OP_SHL_ACC)
                              ? `JMSS_CMD_ADDR_SECOND : `JMSS_CMD_CLEAR_Q;
                        ePulse = 3'd1; end
            5'd5: begin eCode = (op_q == `JMSS_OP_SHL_ACC)
                              ? `JMSS_CMD_ADD_X : `JMSS_CMD_X_TO_Q;
                        ePulse = (op_q == `JMSS_OP_SHL_ACC) ? 3'd1 : 3'd2;
                        eWait = (op_q == `JMSS_OP_SHL_ACC);
                        eSkip = (op_q == `JMSS_OP_SHL_ACC)
                              && flags.firstIsAcc; end
            5'd6: begin eCode = `JMSS_CMD_CLEAR_X; ePulse = 3'd2; end
            5'd7: begin eCode = (op_q == `JMSS_OP_SHL_ACC)
                              ? `JMSS_CMD_SHIFT_ACC : `JMSS_CMD_ADDR_SECOND;
                        ePulse = 3'd2;
                        eWait = (op_q == `JMSS_OP_SHL_ACC)
                              && ~flags.countZero; end
            5'd8: begin eCode = `JMSS_CMD_CPL_X; ePulse = 3'd3;
                        eSkip = (op_q == `JMSS_OP_SHL_ACC); end
            5'd9: begin eCode = `JMSS_CMD_SHIFT_Q; ePulse = 3'd3;
                        eWait = ~flags.countZero;
                        eSkip = (op_q == `JMSS_OP_SHL_ACC); end
            5'd10: begin eCode = (op_q == `JMSS_OP_SHL_ACC)
                               ? `JMSS_CMD_ACCLO_TO_X : `JMSS_CMD_NOTQ_TO_X;
                         ePulse = 3'd5; end
            5'd11: begin eCode = `JMSS_CMD_ADDR_FIRST; ePulse = 3'd5; end
            default: begin eCode = `JMSS_CMD_WRITE_FULL; ePulse = 3'd5;
                           eWait = 1'b1; eLast = 1'b1; end
            endcase
        end
        endcase
    end

    // Commands go out one per pulse enable; a wait holds the step
    always_comb begin
        state_d = state_q;
        step_d  = step_q;
        op_d    = op_q;
        took_d  = took_q;
        cmd_d   = '0;
        cmd_d.pulse = ePulse;
        unique case (state_q)
            jmss_pkg::JMSS_IDLE: begin
                if (start) begin
                    state_d = jmss_pkg::JMSS_RUN;
                    op_d    = opcode;
                    step_d  = 5'd0;
                    took_d  = 1'b0;
                end
            end
            jmss_pkg::JMSS_RUN: begin
                if (pulseEn) begin
                    // Decision latched before any branch-dependent step
                    if (step_q == 5'd0) begin
                        took_d = (op_q == `JMSS_OP_SWITCH)
                               ? swTake(opcode[1:0], flags.switchSel)
                               : takeNow;
                    end
                    if (!eSkip) begin
                        cmd_d.valid = 1'b1;
                        cmd_d.code  = eCode;
                    end
                    // A skipped last step with a wait is a bare hold
                    if (eWait && (!eSkip || eLast)) begin
                        state_d = jmss_pkg::JMSS_WAIT;
                    end else if (eLast || step_q == `JMSS_STEP_MAX) begin
                        state_d = jmss_pkg::JMSS_IDLE;
                    end else begin
                        step_d = step_q + 5'd1;
                    end
                end
            end
            jmss_pkg::JMSS_WAIT: begin
                if (unitDone) begin
                    cmd_d.waitDone = 1'b1;
                    // Zero test taken once the subtract-one step ends
                    if ((op_q == `JMSS_OP_EQ_REP && step_q == 5'd5)
                        || (op_q == `JMSS_OP_ACC_ZERO
                            && step_q == 5'd3)) begin
                        took_d = flags.accZero;
                    end
                    if (eLast) begin
                        state_d = jmss_pkg::JMSS_IDLE;
                    end else begin
                        state_d = jmss_pkg::JMSS_RUN;
                        step_d  = step_q + 5'd1;
                    end
                end
            end
            default: state_d = jmss_pkg::JMSS_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            state_q <= jmss_pkg::JMSS_IDLE;
            step_q  <= 5'd0;
            op_q    <= 6'h00;
            took_q  <= 1'b0;
            cmd_q   <= '0;
        end else begin
            state_q <= state_d;
            step_q  <= step_d;
            op_q    <= op_d;
            took_q  <= took_d;
            cmd_q   <= cmd_d;
        end
    end

    assign cmd     = cmd_q;
    assign busy    = (state_q != jmss_pkg::JMSS_IDLE);
    assign waiting = (state_q == jmss_pkg::JMSS_WAIT);
endmodule // jmss_sequencer

// [testbench/jmss_seq_properties.sv]
`timescale 1ns/1ns
`include "jmss_consts.svh"
module jmss_seq_properties (
    input wire logic                  clk_sys,
    input wire logic                  nrst,
    input wire logic                  pulseEn,
    input wire logic                  start,
    input wire logic [5:0]            opcode,
    input wire jmss_pkg::jmss_flags_t flags,
    input wire logic                  unitDone,
    input wire jmss_pkg::jmss_cmd_t   cmd,
    input wire logic                  busy,
    input wire logic                  waiting
);
    logic [2:0] lastPulse_q;
    logic [2:0] lastPulse_d;
    logic       firstPend_q;
    logic       firstPend_d;

    // Order tracking restarts with every accepted instruction
    always_comb begin
        lastPulse_d = lastPulse_q;
        firstPend_d = firstPend_q;
        if (start && !busy) begin
            lastPulse_d = 3'h0;
            firstPend_d = 1'b1;
        end else if (cmd.valid) begin
            lastPulse_d = cmd.pulse;
            firstPend_d = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            lastPulse_q <= 3'h0;
            firstPend_q <= 1'b0;
        end else begin
            lastPulse_q <= lastPulse_d;
            firstPend_q <= firstPend_d;
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    a_reset_quiet: assert property (disable iff (1'b0)
        !nrst |=> !cmd.valid && !busy) else $error("output active in reset");
    a_pulse_ascend: assert property (
        cmd.valid |-> cmd.pulse >= lastPulse_q) else $error("pulse went back");
    a_wait_holds: assert property (
        waiting && !unitDone |=> !cmd.valid) else $error("step past a wait");
    a_wait_release: assert property (
        waiting && unitDone |=> cmd.waitDone) else $error("wait not released");
    a_wait_cause: assert property (
        cmd.waitDone |-> $past(unitDone) && $past(waiting))
        else $error("wait released without completion");
    a_start_busy: assert property (
        start && !busy |=> busy [*2]) else $error("start not taken");
    a_first_clear: assert property (
        cmd.valid && firstPend_q |-> cmd.code == `JMSS_CMD_CLEAR_X
        && cmd.pulse == 3'h0) else $error("first command wrong");
    a_rotate_five: assert property (
        cmd.valid && cmd.code == `JMSS_CMD_SHIFT_Q_ONE |-> cmd.pulse == 3'h5)
        else $error("q rotate off pulse five");
    a_move_five: assert property (
        cmd.valid && cmd.code == `JMSS_CMD_ADDR_TO_PC |-> cmd.pulse == 3'h5)
        else $error("address move off pulse five");
    a_set_one_four: assert property (
        cmd.valid && cmd.code == `JMSS_CMD_SET_X_ONE
        && opcode == `JMSS_OP_EQ_REP |-> cmd.pulse == 3'h4)
        else $error("set one off pulse four");
endmodule // jmss_seq_properties

bind jmss_sequencer jmss_seq_properties u_props (
    .clk_sys(clk_sys), .nrst(nrst), .pulseEn(pulseEn), .start(start),
    .opcode(opcode), .flags(flags), .unitDone(unitDone), .cmd(cmd),
    .busy(busy), .waiting(waiting));

// [testbench/jmss_unit_model.sv]
`timescale 1ns/1ns
module jmss_unit_model (
    input wire logic       clk_sys,
    input wire logic       nrst,
    input wire logic       waiting,
    input wire logic [7:0] delay,
    output logic           unitDone
);
    logic [7:0] cnt;
    logic       served;

    // One completion per wait; a slow delay stalls the sequencer
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            cnt      <= 8'h00;
            served   <= 1'b0;
            unitDone <= 1'b0;
        end else begin
            unitDone <= 1'b0;
            if (!waiting) begin
                served <= 1'b0;
                cnt    <= 8'h00;
            end else if (!served) begin
                if (cnt >= delay) begin
                    unitDone <= 1'b1;
                    served   <= 1'b1;
                end else begin
                    cnt <= cnt + 8'h01;
                end
            end
        end
    end
endmodule // jmss_unit_model

// [testbench/tb_jump_and_masked_shift_sequencer.sv]
`timescale 1ns/1ns
`include "jmss_consts.svh"
module tb_jump_and_masked_shift_sequencer;
    logic                  clk_sys = 1'b0;
    logic                  nrst = 1'b0;
    logic                  pulseEn = 1'b0;
    logic                  start = 1'b0;
    logic [5:0]            opcode = 6'h00;
    jmss_pkg::jmss_flags_t flags = '0;
    logic                  unitDone;
    jmss_pkg::jmss_cmd_t   cmd;
    logic                  busy;
    logic                  waiting;
    logic [7:0]            delay = 8'h02;
    logic [5:0]            codes[$];
    logic [2:0]            pulses[$];
    int                    nDone;
    int                    cyc = 0;
    int                    failures = 0;
    int                    n_compared = 0;
    typedef logic [5:0] jmss_list_t[$];

    jmss_sequencer dut (.clk_sys(clk_sys), .nrst(nrst), .pulseEn(pulseEn),
        .start(start), .opcode(opcode), .flags(flags), .unitDone(unitDone),
        .cmd(cmd), .busy(busy), .waiting(waiting));
    jmss_unit_model model (.clk_sys(clk_sys), .nrst(nrst), .waiting(waiting),
        .delay(delay), .unitDone(unitDone));

    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) pulseEn <= nrst ? ~pulseEn : 1'b0;
    always @(posedge clk_sys) begin
        if (cmd.valid === 1'b1) begin
            codes.push_back(cmd.code);
            pulses.push_back(cmd.pulse);
        end
        if (cmd.waitDone === 1'b1) nDone++;
        cyc++;
        if (cyc >= 60000) begin
            failures++;
            final_report();
        end
    end

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    function automatic int cnt(logic [5:0] c);
        int n = 0;
        foreach (codes[i]) if (codes[i] === c) n++;
        return n;
    endfunction

    // Expected codes must appear in this order, others may interleave
    function automatic bit inOrder(jmss_list_t e);
        int k = 0;
        foreach (codes[i]) if (k < e.size() && codes[i] === e[k]) k++;
        return k == e.size();
    endfunction

    function automatic logic [2:0] pulseOf(logic [5:0] c);
        foreach (codes[i]) if (codes[i] === c) return pulses[i];
        return 3'h7;
    endfunction

    task automatic run(logic [5:0] op, logic [7:0] f, logic [7:0] d);
        int t = 0;
        codes.delete();
        pulses.delete();
        nDone = 0;
        @(posedge clk_sys);
        opcode <= op;
        flags <= jmss_pkg::jmss_flags_t'(f);
        delay <= d;
        start <= 1'b1;
        @(posedge clk_sys);
        start <= 1'b0;
        do begin
            @(posedge clk_sys);
            #1 t++;
        end while (busy !== 1'b0 && t < 4000);
        check("completion", t < 4000, 1);
        repeat (3) @(posedge clk_sys);
    endtask

    task automatic t_equal();
        // Repeat count assumed already loaded by the preceding repeat
        for (int z = 0; z < 2; z++) begin
            run(`JMSS_OP_EQ_REP, {1'b0, z[0], 6'h00}, 8'h03);
            check("eq core", inOrder({`JMSS_CMD_SUB_X, `JMSS_CMD_CPL_X, `JMSS_CMD_SUB_ONE}), 1);
            check("eq cpl pc", cnt(`JMSS_CMD_CPL_PC), z);
            check("eq restore", inOrder({`JMSS_CMD_SET_X_ONE, `JMSS_CMD_ADD_X}), 1);
            check("eq set pulse", pulseOf(`JMSS_CMD_SET_X_ONE), 3'h4);
            check("eq term", inOrder({`JMSS_CMD_JUMP_TERM, `JMSS_CMD_PC_TO_ADDR, `JMSS_CMD_CLEAR_CWR}), z);
            check("eq waits", nDone, 6);
            check("eq end test", cnt(`JMSS_CMD_END_TEST), 1 - z);
        end
        $display("test equal branch done");
    endtask

    task automatic t_pick();
        for (int b = 0; b < 2; b++) begin
            run(`JMSS_OP_MQ_SIGN, {2'b00, b[0], 5'h00}, 8'h00);
            check("mq first", cnt(`JMSS_CMD_ADDR_FIRST), b);
            check("mq second", cnt(`JMSS_CMD_ADDR_SECOND), 1 - b);
            check("mq seq", inOrder({`JMSS_CMD_CLEAR_PC, `JMSS_CMD_ADDR_TO_PC, `JMSS_CMD_CLEAR_ADDR, `JMSS_CMD_SHIFT_Q_ONE}), 1);
            check("mq rep", cnt(`JMSS_CMD_CLEAR_REP), 1);
            run(`JMSS_OP_ACC_SIGN, {b[0], 7'h00}, 8'h00);
            check("sign first", cnt(`JMSS_CMD_ADDR_FIRST), b);
            check("sign second", cnt(`JMSS_CMD_ADDR_SECOND), 1 - b);
            run(`JMSS_OP_ACC_ZERO, {1'b0, b[0], 6'h00}, 8'h05);
            check("zero pick", inOrder({`JMSS_CMD_SUB_ONE, b ? `JMSS_CMD_ADDR_SECOND : `JMSS_CMD_ADDR_FIRST, `JMSS_CMD_SET_X_ONE, `JMSS_CMD_ADD_X}), 1);
            check("zero other", cnt(b ? `JMSS_CMD_ADDR_FIRST : `JMSS_CMD_ADDR_SECOND), 0);
        end
        $display("test branch pick done");
    endtask

    task automatic t_switch();
        // Selector is the opcode's low bits, here 2
        for (int s = 0; s < 2; s++) begin
            run(`JMSS_OP_SWITCH, {3'b000, s ? 3'b101 : 3'b010, 2'b00}, 8'h00);
            check("sw clear pc", cnt(`JMSS_CMD_CLEAR_PC), 1 - s);
            check("sw move", cnt(`JMSS_CMD_ADDR_TO_PC), 1 - s);
            check("sw release", inOrder({`JMSS_CMD_ADDR_SECOND, `JMSS_CMD_CLEAR_ADDR}), 1);
        end
        $display("test switch branch done");
    endtask

    task automatic t_masked();
        run(`JMSS_OP_MASK_XFER, 8'h00, 8'h01);
        check("xfer", inOrder({`JMSS_CMD_CLEAR_ACC, `JMSS_CMD_READ, `JMSS_CMD_NOTQ_TO_X, `JMSS_CMD_SPLIT_ADD, `JMSS_CMD_ADDR_SECOND, `JMSS_CMD_WRITE_FULL}), 1);
        run(`JMSS_OP_MASK_ADD, 8'h00, 8'h02);
        check("add keep", cnt(`JMSS_CMD_CLEAR_ACC), 0);
        check("add", inOrder({`JMSS_CMD_SPLIT_ADD, `JMSS_CMD_CLEAR_X, `JMSS_CMD_ACCLO_TO_X, `JMSS_CMD_ADDR_SECOND, `JMSS_CMD_WRITE_FULL}), 1);
        run(`JMSS_OP_MASK_MERGE, 8'h00, 8'h14);
        check("merge", inOrder({`JMSS_CMD_CLEAR_ACC, `JMSS_CMD_LOGICAL, `JMSS_CMD_READ, `JMSS_CMD_LOGICAL, `JMSS_CMD_ACCLO_TO_X, `JMSS_CMD_WRITE_FULL}), 1);
        check("merge cpl q", inOrder({`JMSS_CMD_LOGICAL, `JMSS_CMD_CPL_Q, `JMSS_CMD_LOGICAL, `JMSS_CMD_CPL_Q}), 1);
        check("merge cpl n", cnt(`JMSS_CMD_CPL_Q), 2);
        $display("test masked group done");
    endtask

    task automatic t_shift();
        int n0;
        // Count only flagged zero or not, field kept in eight bits
        run(`JMSS_OP_SHL_ACC, 8'h00, 8'h02);
        n0 = nDone;
        check("acc waits", n0, 4);
        check("acc shift", inOrder({`JMSS_CMD_CLEAR_ACC, `JMSS_CMD_READ, `JMSS_CMD_ADD_X, `JMSS_CMD_SHIFT_ACC, `JMSS_CMD_ACCLO_TO_X, `JMSS_CMD_ADDR_FIRST, `JMSS_CMD_WRITE_FULL}), 1);
        run(`JMSS_OP_SHL_ACC, 8'h02, 8'h02);
        check("acc no load", cnt(`JMSS_CMD_READ), 0);
        check("acc rotates", cnt(`JMSS_CMD_SHIFT_ACC), 1);
        run(`JMSS_OP_SHL_ACC, 8'h01, 8'h02);
        check("zero count", nDone, n0 - 1);
        run(`JMSS_OP_SHL_MQ, 8'h00, 8'h03);
        check("mq shift", inOrder({`JMSS_CMD_READ, `JMSS_CMD_CLEAR_Q, `JMSS_CMD_X_TO_Q, `JMSS_CMD_CPL_X, `JMSS_CMD_SHIFT_Q, `JMSS_CMD_NOTQ_TO_X, `JMSS_CMD_ADDR_FIRST, `JMSS_CMD_WRITE_FULL}), 1);
        $display("test shifts done");
    endtask

    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge clk_sys);
        nrst <= 1'b1;
        t_equal();
        t_pick();
        t_switch();
        t_masked();
        t_shift();
        final_report();
    end
endmodule // tb_jump_and_masked_shift_sequencer
